// ==== osd_display_ram_control.sv ====
// Purpose: display entry memory, control registers and oscillator gating
// Assumes: vsync and hsync pins asynchronous; active-low vsync pulse
// Notes: memory is write-only from the core
`default_nettype none
`include "osd_consts.svh"
module osd_display_ram_control
    import osd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    osd_core_if.device bus,
    input wire logic vsync_n,
    input wire logic hsync_n,
    output logic osc_run,
    output logic [2:0] rgb,
    output logic blank
);
    entry_t mem_q [80];
    logic [7:0] page_q, page_d;
    logic en_q, en_d, run_q, run_d, bank_q, bank_d;
    logic [5:0] vstart_q, hstart_q, vspace_q, hspace_q, bgctl_q;
    logic [1:0] vs_sync_q, hs_sync_q;
    logic vs_prev_q, hs_prev_q;
    logic [2:0] line_q, line_d;
    logic [3:0] col_q, col_d;
    logic [2:0] rgb_q, rgb_d, bgcol_q, bgcol_d;
    logic blank_q, blank_d, last_space_q, last_space_d, size0_q, size0_d;
    logic vs_edge, hs_edge, in_win, mem_wr;
    logic [6:0] mem_idx;
    logic [5:0] off;
    entry_t cur;

    assign off = bus.addr[5:0];
    assign in_win = bus.addr[7:6] == 2'b00;
    // prev and sync flops reset high, the idle pin level, so no false edge
    assign vs_edge = vs_prev_q & ~vs_sync_q[1];
    assign hs_edge = hs_prev_q & ~hs_sync_q[1];
    // window writes other than the enable register need enable clear and a stopped oscillator
    assign mem_wr = bus.wr & in_win & ~run_q & ~en_q;
    always_comb begin
        mem_idx = 7'h00;
        if (page_q == `PAGE_LOW) begin
            mem_idx = {1'b0, off};
        end else if (page_q == `PAGE_HIGH && off[5:4] == 2'b00) begin
            mem_idx = 7'd64 + {3'b000, off[3:0]};
        end
    end
    // the core sees only the status byte; memory never reads back
    assign bus.rdata = (bus.addr == `VSYNC_STAT_ADDR) ?
        (8'h00 | ({7'h00, ~vs_sync_q[1]} << `VSYNC_STAT_BIT)) : 8'h00;

    // no reset: entries are undefined until software fills them
    always_ff @(posedge clk) begin
        if (mem_wr && (page_q == `PAGE_LOW ||
                (page_q == `PAGE_HIGH && off[5:4] == 2'b00))) begin
            mem_q[mem_idx] <= bus.wdata[6:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vstart_q <= 6'h00;
            hstart_q <= 6'h00;
            vspace_q <= 6'h00;
            hspace_q <= 6'h00;
            bgctl_q <= 6'h00;
        // position and spacing fields are held here but not used by the simple scan
        end else if (mem_wr && page_q == `PAGE_HIGH) begin
            if (off == `VSTART_OFFSET) vstart_q <= bus.wdata[5:0];
            if (off == `HSTART_OFFSET) hstart_q <= bus.wdata[5:0];
            if (off == `VSPACE_OFFSET) vspace_q <= bus.wdata[5:0];
            if (off == `HSPACE_OFFSET) hspace_q <= bus.wdata[5:0];
            if (off == `BGCTL_OFFSET) bgctl_q <= bus.wdata[5:0];
        end
    end

    always_comb begin
        page_d = page_q;
        en_d = en_q;
        bank_d = bank_q;
        run_d = run_q;
        if (bus.wr && bus.addr == `PAGE_REG_ADDR) page_d = bus.wdata;
        if (bus.wr && bus.addr == `BANK_SEL_ADDR && !en_q && !run_q) begin
            bank_d = bus.wdata[0];
        end
        if (bus.wr && page_q == `PAGE_HIGH && in_win && off == `ENABLE_OFFSET) begin
            en_d = bus.wdata[`ENABLE_BIT];
        end
        // a set enable only arms the start; the display waits for a sync edge,
        // so an enable after flyback costs the rest of that frame
        if (!en_d) begin
            run_d = 1'b0;
        end else if (!run_q && vs_edge) begin
            run_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_q <= 8'h00;
            en_q <= 1'b0;
            // bank select has no defined reset; zero is a safe pick
            bank_q <= 1'b0;
            run_q <= 1'b0;
            vs_sync_q <= 2'b11;
            hs_sync_q <= 2'b11;
            vs_prev_q <= 1'b1;
            hs_prev_q <= 1'b1;
        end else begin
            page_q <= page_d;
            en_q <= en_d;
            bank_q <= bank_d;
            run_q <= run_d;
            vs_sync_q <= {vs_sync_q[0], vsync_n};
            hs_sync_q <= {hs_sync_q[0], hsync_n};
            vs_prev_q <= vs_sync_q[1];
            hs_prev_q <= hs_sync_q[1];
        end
    end

    // simplified scan: one entry per cycle while running, line per hsync
    assign cur = mem_q[{line_q, 4'h0} + {3'b000, col_q}];
    always_comb begin
        line_d = line_q;
        col_d = col_q;
        rgb_d = rgb_q;
        bgcol_d = bgcol_q;
        blank_d = 1'b0;
        last_space_d = last_space_q;
        size0_d = size0_q;
        if (!run_q || vs_edge) begin
            line_d = 3'd0;
            col_d = 4'd0;
            rgb_d = 3'b000;
        // the fifth line repeats until the next frame restarts the scan
        end else if (hs_edge) begin
            line_d = (line_q == 3'd4) ? 3'd4 : line_q + 3'd1;
            col_d = 4'd0;
        end else if (col_q == 4'd0) begin
            size0_d = ~cur[`ENTRY_SIZE_BIT];
            rgb_d = cur[2:0];
            col_d = 4'd1;
        end else begin
            if (cur == `ENTRY_SPACE_CODE) begin
                bgcol_d = bgctl_q[2:0];
                last_space_d = 1'b1;
            end else begin
                blank_d = 1'b1;
                rgb_d = cur[2:0] ^ {2'b00, bank_q};
                last_space_d = 1'b0;
            end
            if (col_q == 4'd15) begin
                // bar in space background at line end for small size
                if (last_space_d && size0_q) begin
                    rgb_d = bgcol_d;
                    blank_d = 1'b1;
                end
            end else begin
                col_d = col_q + 4'd1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_q <= 3'd0;
            col_q <= 4'd0;
            rgb_q <= 3'b000;
            bgcol_q <= 3'b000;
            blank_q <= 1'b0;
            last_space_q <= 1'b0;
            size0_q <= 1'b0;
        end else begin
            line_q <= line_d;
            col_q <= col_d;
            rgb_q <= rgb_d;
            bgcol_q <= bgcol_d;
            blank_q <= blank_d;
            last_space_q <= last_space_d;
            size0_q <= size0_d;
        end
    end

    // every display output comes straight from a flop
    assign osc_run = run_q;
    assign rgb = rgb_q;
    assign blank = blank_q;
endmodule
`default_nettype wire

// ==== osd_consts.svh ====
// Purpose: constants for the display memory and enable control
// Assumes: single 125 MHz clock domain
// Notes: offsets are data-space offsets within the paged window
`ifndef OSD_CONSTS_SVH
`define OSD_CONSTS_SVH
`define PAGE_REG_ADDR 8'hE8
`define PAGE_LOW 8'h20
`define PAGE_HIGH 8'h40
`define VSYNC_STAT_ADDR 8'hE4
`define VSYNC_STAT_BIT 4
`define BANK_SEL_ADDR 8'hED
`define ENABLE_OFFSET 6'h17
`define VSTART_OFFSET 6'h10
`define HSTART_OFFSET 6'h11
`define VSPACE_OFFSET 6'h12
`define HSPACE_OFFSET 6'h13
`define BGCTL_OFFSET 6'h14
`define ENABLE_BIT 0
`define ENTRY_SIZE_BIT 6
`define ENTRY_SPACE_CODE 7'h7F
`define APB_PAGE 12'h000
`define APB_ADDR 12'h004
`define APB_DATA 12'h008
`define APB_STAT 12'h00C
`define APB_BUSY_BIT 0
`endif

// ==== osd_pkg.sv ====
// Purpose: shared types for the display memory control
// Assumes: nothing
// Notes: entry is seven bits, glyph index in the low six
`default_nettype none
package osd_pkg;
    typedef logic [6:0] entry_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01
    } host_state_e;
endpackage
`default_nettype wire

// ==== osd_core_if.sv ====
// Purpose: core data-space write port plus status read between the ends
// Assumes: same clock for both ends
// Notes: write only; one read port for the status byte
`default_nettype none
interface osd_core_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
    modport device (input addr, input wdata, input wr, output rdata);
    modport core (output addr, output wdata, output wr, input rdata);
endinterface
`default_nettype wire

// ==== osd_core_master.sv ====
// Purpose: core-side end taking APB orders and writing display space
// Assumes: APB slave, writes without wait, reads with one wait state
// Notes: each page or data write order costs one core write cycle; address orders cost none
`default_nettype none
`include "osd_consts.svh"
module osd_core_master
    import osd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    osd_core_if.core bus
);
    host_state_e st_q, st_d;
    logic [7:0] addr_q, addr_d, data_q, data_d;
    logic [31:0] rd_q, rd_d;
    logic acc, rd_vld_q, rd_vld_d;
    assign acc = psel & penable;
    // reads take one wait state so that read data comes from a flop
    assign pready = ~(acc & ~pwrite & ~rd_vld_q);
    assign pslverr = 1'b0;
    always_comb begin
        st_d = ST_IDLE;
        addr_d = addr_q;
        data_d = data_q;
        rd_d = rd_q;
        rd_vld_d = 1'b0;
        if (acc && pwrite) begin
            unique case (paddr)
                `APB_PAGE: begin
                    addr_d = `PAGE_REG_ADDR;
                    data_d = pwdata[7:0];
                    st_d = ST_WRITE;
                end
                `APB_ADDR: addr_d = pwdata[7:0];
                `APB_DATA: begin
                    data_d = pwdata[7:0];
                    st_d = ST_WRITE;
                end
                default: st_d = ST_IDLE;
            endcase
        end
        if (acc && !pwrite && !rd_vld_q) begin
            rd_vld_d = 1'b1;
            rd_d = (paddr == `APB_STAT) ? {24'h000000, bus.rdata} : 32'h0000_0000;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            addr_q <= 8'h00;
            data_q <= 8'h00;
            rd_q <= 32'h0000_0000;
            rd_vld_q <= 1'b0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            data_q <= data_d;
            rd_q <= rd_d;
            rd_vld_q <= rd_vld_d;
        end
    end
    assign prdata = rd_q;
    assign bus.addr = (st_q == ST_WRITE) ? addr_q : `VSYNC_STAT_ADDR;
    assign bus.wdata = data_q;
    assign bus.wr = st_q == ST_WRITE;
endmodule
`default_nettype wire

// ==== osd_display_ram_control_chk.sv ====
// Purpose: concurrent checks on the core write port, status and oscillator gating
// Assumes: one clock, reset asynchronous and active high
// Notes: page and enable are tracked from the observed core writes
`default_nettype none
`include "osd_consts.svh"
module osd_display_ram_control_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic [7:0] rdata,
    input wire logic vsync_n,
    input wire logic osc_run,
    input wire logic [2:0] rgb,
    input wire logic blank
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] page_q;
    logic en_q;
    logic [3:0] fall_q;
    // cycles since the raw sync pin fell, saturating so it never wraps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_q <= 8'h00;
            en_q <= 1'b0;
            fall_q <= 4'hF;
        end else begin
            if (wr && addr == `PAGE_REG_ADDR) page_q <= wdata;
            if (wr && page_q == `PAGE_HIGH && addr == 8'h17) en_q <= wdata[0];
            fall_q <= $fell(vsync_n) ? 4'h0 : (fall_q == 4'hF ? fall_q : fall_q + 4'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence en_clear;
        wr && page_q == `PAGE_HIGH && addr == 8'h17 && !wdata[0];
    endsequence
    sequence vs_still;
        $stable(vsync_n)[*4];
    endsequence
    start_on_sync_a: assert property ($rose(osc_run) |-> fall_q <= 4'h6)
        else $error("oscillator started away from a sync edge");
    start_needs_en_a: assert property ($rose(osc_run) |-> en_q)
        else $error("oscillator started with enable clear");
    stop_at_once_a: assert property (en_clear |-> ##[1:2] !osc_run)
        else $error("oscillator kept running after enable clear");
    off_stays_a: assert property ((!en_q)[*3] |-> !osc_run)
        else $error("oscillator running while enable clear");
    stat_bit_a: assert property (vs_still ##0 addr == `VSYNC_STAT_ADDR |-> rdata[4] == !vsync_n)
        else $error("status bit does not show inverted sync");
    stat_rest_a: assert property (addr == `VSYNC_STAT_ADDR |-> (rdata & 8'hEF) == 8'h00)
        else $error("status byte has stray bits");
    no_readback_a: assert property (addr != `VSYNC_STAT_ADDR |-> rdata == 8'h00)
        else $error("display location read back");
    wr_pulse_a: assert property (wr |=> !wr)
        else $error("core write strobe longer than one cycle");
    dark_off_a: assert property ((!osc_run)[*3] |-> !blank)
        else $error("display output active while oscillator off");
    dark_rgb_a: assert property ((!osc_run)[*2] |-> rgb == 3'h0)
        else $error("colour output active while oscillator off");
endmodule
`default_nettype wire

// ==== tb_osd_display_ram_control.sv ====
// Purpose: drives both ends over APB and sync pins and judges the results
// Assumes: APB slave may insert wait states; every wait is bounded
// Notes: scan output is checked here only for the end bar colour; the rest is left to the checker
`default_nettype none
`include "osd_consts.svh"
module tb_osd_display_ram_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, vsync_n, hsync_n, osc_run, blank;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] rgb;
    int n_mismatch, samples_checked;
    osd_core_if link();
    osd_display_ram_control osd_display_ram_control_i (.clk(clk), .rst(rst), .bus(link),
        .vsync_n(vsync_n), .hsync_n(hsync_n), .osc_run(osc_run), .rgb(rgb), .blank(blank));
    osd_core_master osd_core_master_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(link));
    osd_display_ram_control_chk osd_display_ram_control_chk_i (.clk(clk), .rst(rst),
        .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rdata(link.rdata),
        .vsync_n(vsync_n), .osc_run(osc_run), .rgb(rgb), .blank(blank));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] r);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            give_verdict();
        end
        r = prdata;
        check("slave error", pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr8(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic poke(input logic [7:0] a, input logic [7:0] d);
        wr8(`APB_ADDR, a);
        wr8(`APB_DATA, d);
    endtask
    task automatic vs(input logic v);
        vsync_n <= v;
        cyc(6);
    endtask
    task automatic wait_osc(input logic v);
        int n;
        n = 0;
        while (osc_run !== v && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (osc_run !== v) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    task automatic s_status;
        logic [31:0] r;
        wr8(`APB_ADDR, `VSYNC_STAT_ADDR);
        apb(1'b0, `APB_STAT, 8'h00, r);
        check("status high", r, 32'h0);
        vs(1'b0);
        apb(1'b0, `APB_STAT, 8'h00, r);
        check("status low", r, 32'h10);
        vs(1'b1);
        wr8(`APB_ADDR, 8'h17);
        apb(1'b0, `APB_DATA, 8'h00, r);
        check("no readback", r, 32'h0);
    endtask
    task automatic s_fill;
        wr8(`APB_PAGE, `PAGE_LOW);
        for (int i = 0; i < 64; i++) poke(8'(i), {2'b00, 6'(i + 1)});
        wr8(`APB_PAGE, `PAGE_HIGH);
        for (int i = 0; i < 16; i++) poke(8'(i), (i == 15) ? 8'h7F : 8'h01);
        poke(8'h14, 8'h05);
        check("idle while filling", osc_run, 1'b0);
    endtask
    task automatic s_start_stop;
        poke(8'h17, 8'h01);
        cyc(20);
        check("no start before sync", osc_run, 1'b1 ^ 1'b1);
        vs(1'b0);
        wait_osc(1'b1);
        check("start on sync", osc_run, 1'b1);
        repeat (4) begin
            hsync_n <= 1'b0;
            cyc(2);
            hsync_n <= 1'b1;
            cyc(30);
        end
        check("end bar colour", rgb, 3'h5);
        // writes while running must be dropped without disturbing the display
        poke(8'h0F, 8'h01);
        poke(`BANK_SEL_ADDR, 8'h01);
        cyc(3);
        check("display undisturbed", rgb, 3'h5);
        check("still running", osc_run, 1'b1);
        vs(1'b1);
        poke(8'h17, 8'h00);
        cyc(3);
        check("stop at once", osc_run, 1'b0);
    endtask
    task automatic s_late;
        vs(1'b0);
        poke(8'h17, 8'h01);
        cyc(30);
        check("late enable waits", osc_run, 1'b0);
        vs(1'b1);
        vs(1'b0);
        wait_osc(1'b1);
        check("next frame start", osc_run, 1'b1);
        poke(8'h17, 8'h00);
        cyc(3);
        check("stop again", osc_run, 1'b0);
        vs(1'b1);
    endtask
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        vsync_n = 1'b1;
        hsync_n = 1'b1;
        cyc(2);
        rst <= 1'b0;
        s_status();
        s_fill();
        s_start_stop();
        s_late();
        give_verdict();
    end
endmodule
`default_nettype wire
